// *** antenna_driver_cfg.svh ***
// Register map, reset values, read masks and timing figures for the antenna driver block.
// Assumes a 100 MHz system clock and a Wishbone slave with word-aligned registers.
`ifndef ANTENNA_DRIVER_CFG_SVH
`define ANTENNA_DRIVER_CFG_SVH
`define CLK_PERIOD_NS 10
`define IDX_DRV_OUT_CTRL 8'h14
`define IDX_DRV_AUTO_CTRL 8'h15
`define IDX_DRV_SRC_SEL 8'h16
`define ADR_DRV_OUT_CTRL 8'h50
`define ADR_DRV_AUTO_CTRL 8'h54
`define ADR_DRV_SRC_SEL 8'h58
`define RST_DRV_OUT_CTRL 8'h80
`define RST_DRV_AUTO_CTRL 8'h00
`define RST_DRV_SRC_SEL 8'h10
`define CTRL_RD_MASK 8'hfb
`define AUTO_RD_MASK 8'hef
`define SEL_RD_MASK 8'h3f
`define T_ADT_NS 60000
`define T_IDT_NS 300000
`define T_RFW_NS 5000
`define ADT_CYCLES ((`T_ADT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define IDT_CYCLES ((`T_IDT_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RFW_CYCLES ((`T_RFW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// *** antenna_driver_control.sv ***
// Antenna driver control: three Wishbone registers steer the two antenna drivers, the signal
// output pin, automatic switch-on with collision avoidance, auto switch-off and field wake-up.
// Assumes all data inputs are synchronous to clk except field_detected, which is synchronised.
//
// Local design decision: register access over Wishbone.
`timescale 1ns/100ps
`include "antenna_driver_cfg.svh"

module antenna_driver_control
	import antenna_driver_pkg::*;
#(
	parameter int ADT_CYC = `ADT_CYCLES,
	parameter int IDT_CYC = `IDT_CYCLES,
	parameter int RFW_CYC = `RFW_CYCLES,
	parameter int CNT_W = 20,
	parameter int COND_W = 6
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic arst_n,
	// Wishbone slave.
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Transmitter and analog inputs.
	input wire logic carrier,
	input wire logic coder_envelope,
	input wire logic tx_serial_data,
	input wire logic tx_last_bit_done,
	input wire logic envelope_input_pin,
	input wire logic field_detected,
	input wire logic soft_power_down,
	input wire logic [COND_W-1:0] modulation_conductance_setting,
	// Pins and status towards the analog part and power control.
	output pin_s antenna_driver_a_pin,
	output pin_s antenna_driver_b_pin,
	output pin_s signal_output_pin,
	output logic full_ask_select,
	output logic [COND_W-1:0] conductance_out,
	output logic wake_request,
	output logic collision_avoid_active,
	output logic [1:0] random_slot
);
	out_ctrl_s ctrl_q, ctrl_d;
	auto_ctrl_s auto_q, auto_d;
	src_sel_s sel_q, sel_d;
	auto_state_e state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [1:0] slot_q, slot_d;
	logic [7:0] lfsr_q;
	logic ack_q;
	logic [31:0] rdat_q, rdat_d;
	logic [1:0] field_sync_q;
	logic wake_q;
	logic full_ask_q;
	logic [COND_W-1:0] cond_q;
	logic [1:0] drv_lvl_q, drv_oe_q;
	logic sig_lvl_q, sig_oe_q, sig_lvl_d, sig_oe_d;
	logic fire;

	// Bus decode. A write takes effect at the edge where the master sees ack.
	wire field = field_sync_q[1];
	wire bus_req = wb_cyc_i & wb_stb_i;
	wire take = bus_req & ~ack_q;
	wire wr_lane = bus_req & ack_q & wb_we_i & wb_sel_i[0];
	wire hit_ctrl = (wb_adr_i == `ADR_DRV_OUT_CTRL);
	wire hit_auto = (wb_adr_i == `ADR_DRV_AUTO_CTRL);
	wire hit_sel = (wb_adr_i == `ADR_DRV_SRC_SEL);
	wire wr_ctrl = wr_lane & hit_ctrl;
	wire wr_auto = wr_lane & hit_auto;
	wire wr_sel = wr_lane & hit_sel;
	wire out_ctrl_s wctrl = wb_dat_i[7:0];
	wire [7:0] rd_byte = hit_ctrl ? (ctrl_q & `CTRL_RD_MASK) :
		hit_auto ? (auto_q & `AUTO_RD_MASK) :
		hit_sel ? (sel_q & `SEL_RD_MASK) : 8'h00;
	assign rdat_d = take ? {24'h000000, rd_byte} : rdat_q;

	// The field-check guard only stops enables rising; clearing is always allowed.
	wire guard = wctrl.field_check_guard & field;
	wire [1:0] wen = {wctrl.drv_b_enable, wctrl.drv_a_enable};
	wire [1:0] cur_en = {ctrl_q.drv_b_enable, ctrl_q.drv_a_enable};
	wire [1:0] sw_en = guard ? (wen & cur_en) : wen;
	wire auto_off_hit = auto_q.auto_driver_off & tx_last_bit_done;
	wire [1:0] auto_en = {auto_q.drv_b_auto_enable, auto_q.drv_a_auto_enable};
	wire any_auto = |auto_en;
	wire [1:0] en_after_off = auto_off_hit ? 2'b00 : cur_en;
	wire [1:0] en_after_sw = wr_ctrl ? sw_en : en_after_off;
	wire [1:0] en_next = fire ? (en_after_sw | auto_en) : en_after_sw;

	always_comb begin
		ctrl_d = wr_ctrl ? wctrl : ctrl_q;
		ctrl_d.field_check_guard = 1'b0;
		ctrl_d.drv_b_enable = en_next[1];
		ctrl_d.drv_a_enable = en_next[0];
	end

	// Hardware clears the initial check on switch-on; a software write in the same cycle wins.
	always_comb begin
		auto_d = auto_q;
		if (fire) begin
			auto_d.initial_field_check = 1'b0;
		end
		if (wr_auto) begin
			auto_d = wb_dat_i[7:0];
		end
		auto_d.reserved = 1'b0;
	end

	always_comb begin
		sel_d = wr_sel ? src_sel_s'(wb_dat_i[7:0]) : sel_q;
		sel_d.reserved = 2'b00;
	end

	// Automatic switch-on. The active delay is stretched by n wait slots under collision
	// avoidance, so that two initiators seeing the same field drop do not collide.
	wire [CNT_W-1:0] adt_end = CNT_W'(ADT_CYC - 1);
	wire [CNT_W-1:0] slot_ext = CNT_W'(RFW_CYC) * CNT_W'(slot_q);
	wire [CNT_W-1:0] active_end = auto_q.collision_avoid_enable ? (adt_end + slot_ext) : adt_end;
	wire [CNT_W-1:0] init_end = CNT_W'(IDT_CYC - 1);
	wire [CNT_W-1:0] cnt_inc = cnt_q + CNT_W'(1);

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		slot_d = slot_q;
		fire = 1'b0;
		case (state_q)
			AUTO_IDLE: begin
				cnt_d = '0;
				if (any_auto && field) begin
					state_d = AUTO_WAIT_OFF;
				end else if (any_auto && auto_q.initial_field_check) begin
					state_d = AUTO_INIT_DLY;
				end
			end
			AUTO_INIT_DLY: begin
				cnt_d = cnt_inc;
				if (!any_auto || !auto_q.initial_field_check) begin
					state_d = AUTO_IDLE;
				end else if (field) begin
					state_d = AUTO_WAIT_OFF;
				end else if (cnt_q >= init_end) begin
					fire = 1'b1;
					state_d = AUTO_IDLE;
				end
			end
			AUTO_WAIT_OFF: begin
				cnt_d = '0;
				if (!any_auto) begin
					state_d = AUTO_IDLE;
				end else if (!field) begin
					slot_d = lfsr_q[1:0];
					state_d = AUTO_ACTIVE_DLY;
				end
			end
			AUTO_ACTIVE_DLY: begin
				cnt_d = cnt_inc;
				if (!any_auto) begin
					state_d = AUTO_IDLE;
				end else if (field) begin
					state_d = AUTO_WAIT_OFF;
				end else if (cnt_q >= active_end) begin
					fire = 1'b1;
					state_d = AUTO_IDLE;
				end
			end
			default: begin
				state_d = AUTO_IDLE;
			end
		endcase
	end

	// Driver source and pin levels.
	wire drv_src_e src = drv_src_e'(sel_q.driver_source_field);
	wire src_lvl = (src == SRC_CODER) ? coder_envelope :
		(src == SRC_ENV_PIN) ? envelope_input_pin :
		(src == SRC_HIGH);
	wire [1:0] inv_on = {ctrl_q.drv_b_invert_when_on, ctrl_q.drv_a_invert_when_on};
	wire [1:0] inv_off = {ctrl_q.drv_b_invert_when_off, ctrl_q.drv_a_invert_when_off};
	wire [1:0] cw = {ctrl_q.drv_b_continuous_wave, 1'b0};
	// Soft power-down does not touch the enables; only the tristate source floats the drivers.
	wire drv_oe_d = (src != SRC_TRISTATE);
	logic [1:0] drv_lvl_d;

	for (genvar i = 0; i < 2; i++) begin : g_drv
		wire on_lvl = carrier & (cw[i] | src_lvl);
		assign drv_lvl_d[i] = cur_en[i] ? (on_lvl ^ inv_on[i]) : inv_off[i];
	end

	always_comb begin
		sig_lvl_d = 1'b0;
		sig_oe_d = 1'b1;
		case (sig_src_e'(sel_q.signal_out_source_field))
			SIG_TRISTATE: sig_oe_d = 1'b0;
			SIG_LOW: sig_lvl_d = 1'b0;
			SIG_HIGH: sig_lvl_d = 1'b1;
			SIG_CODER: sig_lvl_d = coder_envelope;
			SIG_SERIAL: sig_lvl_d = tx_serial_data;
			default: sig_oe_d = 1'b0;
		endcase
	end

	wire wake_d = auto_q.field_wake_enable & soft_power_down & field;
	wire [COND_W-1:0] cond_d = auto_q.force_full_ask ? '0 : modulation_conductance_setting;
	wire [7:0] lfsr_d = {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_q <= `RST_DRV_OUT_CTRL;
			auto_q <= `RST_DRV_AUTO_CTRL;
			sel_q <= `RST_DRV_SRC_SEL;
			ack_q <= 1'b0;
			rdat_q <= 32'h00000000;
		end else begin
			ctrl_q <= ctrl_d;
			auto_q <= auto_d;
			sel_q <= sel_d;
			ack_q <= take;
			rdat_q <= rdat_d;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			state_q <= AUTO_IDLE;
			cnt_q <= '0;
			slot_q <= 2'h0;
			lfsr_q <= 8'h01;
			field_sync_q <= 2'b00;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			slot_q <= slot_d;
			lfsr_q <= lfsr_d;
			field_sync_q <= {field_sync_q[0], field_detected};
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			drv_lvl_q <= 2'b00;
			drv_oe_q <= 2'b00;
			sig_lvl_q <= 1'b0;
			sig_oe_q <= 1'b0;
			wake_q <= 1'b0;
			full_ask_q <= 1'b0;
			cond_q <= '0;
		end else begin
			drv_lvl_q <= drv_lvl_d;
			drv_oe_q <= {drv_oe_d, drv_oe_d};
			sig_lvl_q <= sig_lvl_d;
			sig_oe_q <= sig_oe_d;
			wake_q <= wake_d;
			full_ask_q <= auto_q.force_full_ask;
			cond_q <= cond_d;
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;
	assign antenna_driver_a_pin = '{lvl: drv_lvl_q[0], oe: drv_oe_q[0]};
	assign antenna_driver_b_pin = '{lvl: drv_lvl_q[1], oe: drv_oe_q[1]};
	assign signal_output_pin = '{lvl: sig_lvl_q, oe: sig_oe_q};
	assign full_ask_select = full_ask_q;
	assign conductance_out = cond_q;
	assign wake_request = wake_q;
	assign collision_avoid_active = auto_q.collision_avoid_enable;
	assign random_slot = slot_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!arst_n);

	// These check the bus handshake, the field input, the field-check guard, auto switch-off and automatic switch-on.
	AST_WB_ACK_ONE: assert property (bus_req & !ack_q |=> ack_q ##1 !ack_q)
		else $error("ack did not pulse for one cycle");
	AST_FIELD_SYNC: assert property ($past(arst_n, 2) |->
		field == $past(field_detected, 2))
		else $error("field input not seen two cycles later");
	AST_GUARD_BLOCKS: assert property (wr_ctrl & wctrl.field_check_guard
		& field & !fire & !ctrl_q.drv_a_enable |=> !ctrl_q.drv_a_enable)
		else $error("enable rose despite field check and field present");
	AST_AUTO_OFF: assert property (auto_off_hit & !wr_ctrl & !fire |=> cur_en == 2'b00)
		else $error("drivers still on after last bit with auto-off");
	AST_NO_FIRE_IN_FIELD: assert property (field |-> !fire)
		else $error("automatic switch-on while a field is present");
	AST_INIT_END: assert property ((state_q == AUTO_INIT_DLY) & fire |->
		cnt_q == init_end)
		else $error("initial delay switch-on at the wrong count");
	AST_ACTIVE_END: assert property ((state_q == AUTO_ACTIVE_DLY) & fire |->
		cnt_q >= adt_end && cnt_q <= adt_end + slot_ext)
		else $error("active delay switch-on at the wrong count");
	AST_INIT_CLEAR: assert property (fire & !wr_auto |=> !auto_q.initial_field_check
		&& (cur_en & $past(auto_en)) == $past(auto_en))
		else $error("switch-on did not clear initial check or set enable");

	// These check the driver pins against the control bits and the source field.
	AST_DRV_A_ON: assert property (ctrl_q.drv_a_enable |=>
		antenna_driver_a_pin.lvl == ($past(carrier & src_lvl) ^ $past(inv_on[0])))
		else $error("driver A level wrong while enabled");
	AST_DRV_A_OFF: assert property (!ctrl_q.drv_a_enable |=>
		antenna_driver_a_pin.lvl == $past(ctrl_q.drv_a_invert_when_off))
		else $error("driver A level wrong while disabled");
	AST_DRV_B_ON: assert property (ctrl_q.drv_b_enable & !ctrl_q.drv_b_continuous_wave |=>
		antenna_driver_b_pin.lvl == ($past(carrier & src_lvl) ^ $past(inv_on[1])))
		else $error("driver B level wrong while enabled");
	AST_DRV_B_OFF: assert property (!ctrl_q.drv_b_enable |=>
		antenna_driver_b_pin.lvl == $past(ctrl_q.drv_b_invert_when_off))
		else $error("driver B level wrong while disabled");
	AST_DRV_B_CW: assert property (ctrl_q.drv_b_enable & ctrl_q.drv_b_continuous_wave |=>
		antenna_driver_b_pin.lvl == ($past(carrier) ^ $past(inv_on[1])))
		else $error("driver B not carrying plain carrier in continuous wave");
	AST_SRC_CODER: assert property ((src == SRC_CODER) & ctrl_q.drv_a_enable
		& !ctrl_q.drv_a_invert_when_on |=>
		antenna_driver_a_pin.lvl == $past(carrier & coder_envelope))
		else $error("driver A not following the coder envelope");
	AST_SRC_ENV_PIN: assert property ((src == SRC_ENV_PIN) & ctrl_q.drv_b_enable
		& !ctrl_q.drv_b_continuous_wave & !ctrl_q.drv_b_invert_when_on |=>
		antenna_driver_b_pin.lvl == $past(carrier & envelope_input_pin))
		else $error("driver B not following the envelope input pin");
	AST_SRC_HIGH: assert property ((src == SRC_HIGH) & ctrl_q.drv_a_enable |=>
		antenna_driver_a_pin.lvl == ($past(carrier) ^ $past(ctrl_q.drv_a_invert_when_on)))
		else $error("driver A high source not following its invert bit");
	AST_DRV_ACTIVE: assert property ((src != SRC_TRISTATE) |=>
		antenna_driver_a_pin.oe && antenna_driver_b_pin.oe)
		else $error("drivers floating with an active source");
	AST_TRISTATE: assert property ((src == SRC_TRISTATE) |=> !antenna_driver_a_pin.oe
		&& !antenna_driver_b_pin.oe)
		else $error("drivers not floating with tristate source");

	// These check the signal output pin for each documented source code.
	AST_SIGNAL_OUTPUT_PIN_SERIAL: assert property (sel_q.signal_out_source_field == SIG_SERIAL |=>
		signal_output_pin.oe && signal_output_pin.lvl == $past(tx_serial_data))
		else $error("signal output not carrying serial data");
	AST_SIGNAL_OUTPUT_PIN_LOW: assert property (sel_q.signal_out_source_field == SIG_LOW |=>
		signal_output_pin.oe && !signal_output_pin.lvl)
		else $error("signal output not driven low");
	AST_SIGNAL_OUTPUT_PIN_HIGH: assert property (sel_q.signal_out_source_field == SIG_HIGH |=>
		signal_output_pin.oe && signal_output_pin.lvl)
		else $error("signal output not driven high");
	AST_SIGNAL_OUTPUT_PIN_CODER: assert property (sel_q.signal_out_source_field == SIG_CODER |=>
		signal_output_pin.oe && signal_output_pin.lvl == $past(coder_envelope))
		else $error("signal output not carrying the coder envelope");
	AST_SIGNAL_OUTPUT_PIN_FLOAT: assert property (sel_q.signal_out_source_field == SIG_TRISTATE |=>
		!signal_output_pin.oe)
		else $error("signal output driven with tristate selected");

	// These check wake-up and the forced full modulation depth.
	AST_WAKE: assert property (auto_q.field_wake_enable & soft_power_down & field |=>
		wake_request)
		else $error("no wake request on field in soft power-down");
	AST_FULL_ASK: assert property (auto_q.force_full_ask |=> conductance_out == '0
		&& full_ask_select)
		else $error("conductance not overridden under forced full ASK");
endmodule

// *** antenna_driver_control_tb.sv ***
// Self-checking bench for antenna_driver_control: register access, pin levels, guard,
// auto switch-off, full ASK, wake and automatic switch-on.
// Assumes the package and configuration header are compiled first.
`timescale 1ns/100ps
`include "antenna_driver_cfg.svh"
module antenna_driver_control_tb
	import antenna_driver_pkg::*;
;
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'h0;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack;
	logic carrier = 1'b1;
	logic coder = 1'b0;
	logic serial = 1'b0;
	logic last_bit = 1'b0;
	logic env_pin = 1'b0;
	logic remote_on = 1'b0;
	logic spd = 1'b0;
	logic [5:0] cond = 6'h2a;
	logic field;
	pin_s pa;
	pin_s pb;
	pin_s ps;
	logic full_ask;
	logic wake;
	logic ca_act;
	logic [5:0] cond_o;
	logic [1:0] slot;
	logic [31:0] rd;
	int err_total = 0;
	int check_count = 0;
	logic [7:0] t_ctrl [10] = '{8'h03, 8'h43, 8'h83, 8'h30, 8'h0a, 8'h02, 8'h53, 8'h03, 8'h03, 8'h03};
	logic [7:0] t_sel [10] = '{8'h10, 8'h10, 8'h10, 8'h20, 8'h10, 8'h10, 8'h30, 8'h20, 8'h00, 8'h10};
	logic [2:0] t_in [10] = '{3'h1, 3'h1, 3'h0, 3'h2, 3'h0, 3'h0, 3'h0, 3'h2, 3'h4, 3'h5};
	logic [3:0] t_sig [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h3};

	localparam int ADT_T = 8;
	localparam int IDT_T = 16;
	localparam int RFW_T = 2;

	always #5 clk = ~clk;

	rf_field_model rf_field_model_i (.clk(clk), .remote_on(remote_on), .field_detected(field));

	antenna_driver_control #(.ADT_CYC(ADT_T), .IDT_CYC(IDT_T), .RFW_CYC(RFW_T))
		antenna_driver_control_i (
		.clk(clk), .arst_n(arst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.carrier(carrier), .coder_envelope(coder), .tx_serial_data(serial),
		.tx_last_bit_done(last_bit), .envelope_input_pin(env_pin), .field_detected(field),
		.soft_power_down(spd), .modulation_conductance_setting(cond),
		.antenna_driver_a_pin(pa), .antenna_driver_b_pin(pb), .signal_output_pin(ps),
		.full_ask_select(full_ask), .conductance_out(cond_o), .wake_request(wake),
		.collision_avoid_active(ca_act), .random_slot(slot));

	task automatic tick(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One classic cycle; the request is held until ack is sampled high.
	task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h1;
		wdat <= {24'h0, d};
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		check(rd, {24'h0, e});
	endtask

	function automatic logic [1:0] drv_exp(input logic [1:0] s, input logic en, cw, ion, ioff,
		input logic cod, env);
		logic v;
		v = (s == 2'h1) ? cod : (s == 2'h2) ? env : 1'b1;
		if (s == 2'h0) return 2'b00;
		return en ? {(carrier & (cw | v)) ^ ion, 1'b1} : {ioff, 1'b1};
	endfunction

	task automatic wrap_up();
		$display("Comparisons %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	initial begin
		#200000;
		err_total++;
		wrap_up();
	end

	initial begin
		logic [7:0] c;
		logic [1:0] s;
		logic [1:0] e;
		int n;
		tick(20);
		arst_n <= 1'b1;
		rd_chk(`ADR_DRV_OUT_CTRL, `RST_DRV_OUT_CTRL & `CTRL_RD_MASK);
		rd_chk(`ADR_DRV_AUTO_CTRL, `RST_DRV_AUTO_CTRL);
		rd_chk(`ADR_DRV_SRC_SEL, `RST_DRV_SRC_SEL);
		bus(1'b1, 8'h5c, 8'hff);
		rd_chk(8'h5c, 8'h00);
		bus(1'b1, `ADR_DRV_OUT_CTRL, 8'hff);
		rd_chk(`ADR_DRV_OUT_CTRL, 8'hfb);
		bus(1'b1, `ADR_DRV_SRC_SEL, 8'hff);
		rd_chk(`ADR_DRV_SRC_SEL, 8'h3f);
		for (int i = 0; i < 10; i++) begin
			c = t_ctrl[i];
			s = t_sel[i][5:4];
			{spd, env_pin, coder} <= t_in[i];
			bus(1'b1, `ADR_DRV_SRC_SEL, t_sel[i]);
			bus(1'b1, `ADR_DRV_OUT_CTRL, c);
			tick(3);
			check({30'h0, pa}, {30'h0, drv_exp(s, c[0], 1'b0, c[6], c[4], t_in[i][0], t_in[i][1])});
			check({30'h0, pb}, {30'h0, drv_exp(s, c[1], c[3], c[7], c[5], t_in[i][0], t_in[i][1])});
		end
		spd <= 1'b0;
		coder <= 1'b1;
		serial <= 1'b1;
		for (int i = 0; i < 6; i++) begin
			bus(1'b1, `ADR_DRV_SRC_SEL, {4'h1, t_sig[i]});
			tick(3);
			e = (t_sig[i] == 4'h2 || t_sig[i] == 4'h4 || t_sig[i] == 4'h5) ? 2'b11 :
				(t_sig[i] == 4'h1) ? 2'b01 : 2'b00;
			check({30'h0, ps.lvl & e[0], ps.oe}, {30'h0, e});
		end
		bus(1'b1, `ADR_DRV_OUT_CTRL, 8'h00);
		remote_on <= 1'b1;
		tick(6);
		bus(1'b1, `ADR_DRV_OUT_CTRL, 8'h07);
		rd_chk(`ADR_DRV_OUT_CTRL, 8'h00);
		bus(1'b1, `ADR_DRV_OUT_CTRL, 8'h03);
		rd_chk(`ADR_DRV_OUT_CTRL, 8'h03);
		remote_on <= 1'b0;
		tick(6);
		bus(1'b1, `ADR_DRV_AUTO_CTRL, 8'h80);
		last_bit <= 1'b1;
		tick(1);
		last_bit <= 1'b0;
		tick(2);
		rd_chk(`ADR_DRV_OUT_CTRL, 8'h00);
		bus(1'b1, `ADR_DRV_AUTO_CTRL, 8'h40);
		tick(3);
		check({31'h0, full_ask}, 32'h1);
		check({26'h0, cond_o}, 32'h0);
		bus(1'b1, `ADR_DRV_AUTO_CTRL, 8'h00);
		tick(3);
		check({26'h0, cond_o}, 32'h2a);
		spd <= 1'b1;
		bus(1'b1, `ADR_DRV_AUTO_CTRL, 8'h20);
		remote_on <= 1'b1;
		tick(6);
		check({31'h0, wake}, 32'h1);
		remote_on <= 1'b0;
		spd <= 1'b0;
		tick(6);
		check({31'h0, wake}, 32'h0);
		bus(1'b1, `ADR_DRV_AUTO_CTRL, 8'h07);
		tick(5);
		rd_chk(`ADR_DRV_OUT_CTRL, 8'h00);
		tick(40);
		rd_chk(`ADR_DRV_OUT_CTRL, 8'h03);
		rd_chk(`ADR_DRV_AUTO_CTRL, 8'h03);
		bus(1'b1, `ADR_DRV_OUT_CTRL, 8'h00);
		bus(1'b1, `ADR_DRV_AUTO_CTRL, 8'h0b);
		tick(2);
		check({31'h0, ca_act}, 32'h1);
		remote_on <= 1'b1;
		tick(6);
		remote_on <= 1'b0;
		tick(4);
		rd_chk(`ADR_DRV_OUT_CTRL, 8'h00);
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pa.lvl !== 1'b1 && n < 60);
		check(n, ADT_T - 1 + RFW_T * slot);
		tick(4);
		rd_chk(`ADR_DRV_OUT_CTRL, 8'h03);
		wrap_up();
	end
endmodule

// *** antenna_driver_pkg.sv ***
// Types shared by the antenna driver control block: register layouts, pin carrier, states.
// Assumes nothing beyond a SystemVerilog compiler.
package antenna_driver_pkg;
	typedef struct packed {
		logic drv_b_invert_when_on;
		logic drv_a_invert_when_on;
		logic drv_b_invert_when_off;
		logic drv_a_invert_when_off;
		logic drv_b_continuous_wave;
		logic field_check_guard;
		logic drv_b_enable;
		logic drv_a_enable;
	} out_ctrl_s;
	typedef struct packed {
		logic auto_driver_off;
		logic force_full_ask;
		logic field_wake_enable;
		logic reserved;
		logic collision_avoid_enable;
		logic initial_field_check;
		logic drv_b_auto_enable;
		logic drv_a_auto_enable;
	} auto_ctrl_s;
	typedef struct packed {
		logic [1:0] reserved;
		logic [1:0] driver_source_field;
		logic [3:0] signal_out_source_field;
	} src_sel_s;
	typedef struct packed {
		logic lvl;
		logic oe;
	} pin_s;
	typedef enum logic [1:0] {
		SRC_TRISTATE = 2'h0,
		SRC_CODER = 2'h1,
		SRC_ENV_PIN = 2'h2,
		SRC_HIGH = 2'h3
	} drv_src_e;
	typedef enum logic [3:0] {
		SIG_TRISTATE = 4'h0,
		SIG_LOW = 4'h1,
		SIG_HIGH = 4'h2,
		SIG_CODER = 4'h4,
		SIG_SERIAL = 4'h5
	} sig_src_e;
	typedef enum logic [1:0] {
		AUTO_IDLE = 2'b00,
		AUTO_WAIT_OFF = 2'b01,
		AUTO_ACTIVE_DLY = 2'b11,
		AUTO_INIT_DLY = 2'b10
	} auto_state_e;
endpackage

// *** rf_field_model.sv ***
// Remote RF field seen by the level detector beside the antenna.
// Assumes the bench decides when a remote field is present; the model runs off clk.
`timescale 1ns/100ps
module rf_field_model (
	// Clock.
	input wire logic clk,
	// Bench control.
	input wire logic remote_on,
	// Detector output.
	output logic field_detected
);
	initial field_detected = 1'b0;
	// Only the remote field is reported, never the block's own carrier.
	always @(posedge clk) begin
		field_detected <= remote_on;
	end
endmodule
